// ---- counter_pkg.sv ----
// Shared constants and types for the dual up/down Gray-code counter
package counter_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int unsigned CHANNELS    = 2;
  localparam int unsigned COUNT_WIDTH = 24;
  localparam int unsigned GRAY_WIDTH  = 3;
  localparam int unsigned ADDR_WIDTH  = 4;
  localparam int unsigned DATA_WIDTH  = 32;

  // ----------------------------------------------------------------
  // Register offsets (word addresses on the plain port)
  // ----------------------------------------------------------------
  localparam logic [ADDR_WIDTH-1:0] CFG0_ADDR    = 4'h0;
  localparam logic [ADDR_WIDTH-1:0] CFG1_ADDR    = 4'h1;
  localparam logic [ADDR_WIDTH-1:0] COUNT0_ADDR  = 4'h2;
  localparam logic [ADDR_WIDTH-1:0] COUNT1_ADDR  = 4'h3;
  localparam logic [ADDR_WIDTH-1:0] STATUS_ADDR  = 4'h4;
  localparam logic [ADDR_WIDTH-1:0] MASK_ADDR    = 4'h5;
  localparam logic [ADDR_WIDTH-1:0] ERRCODE_ADDR = 4'h6;

  // ----------------------------------------------------------------
  // Configuration field positions and reset value
  // ----------------------------------------------------------------
  localparam int unsigned CFG_LEVEL_BIT  = 0;
  localparam int unsigned CFG_MODE_LSB   = 1;
  localparam int unsigned CFG_ENABLE_BIT = 3;
  localparam logic [3:0]  CFG_RESET      = 4'h0;

  // Status bits per channel: fault bit at 2*ch, zero-track event at 2*ch+1
  localparam int unsigned STAT_WIDTH = 4;

  // Error codes
  localparam logic [7:0] ERR_NONE     = 8'h00;
  localparam logic [7:0] ERR_OVERFLOW = 8'h01;
  localparam logic [7:0] ERR_GRAY     = 8'h02;

  // ----------------------------------------------------------------
  // Modes of operation
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_COUNT_DIR   = 2'h0,
    MODE_COUNT_FIXED = 2'h1,
    MODE_DECODER     = 2'h2,
    MODE_RESERVED    = 2'h3
  } mode_e;

  typedef struct packed {
    logic  enable;
    mode_e mode;
    logic  level_24v;
  } chan_cfg_s;

  typedef struct packed {
    logic a;
    logic b;
    logic z;
  } field_in_s;

endpackage : counter_pkg

// ---- dual_updown_gray_counter.sv ----
// Dual 24-bit up/down counter with Gray decoder mode and fault status
//
// Summary of operation
// - Two channels, fully independent state.
// - Per-channel 5 V / 24 V level select.
// - Count on A, direction B, Z clears.
// - Decoder mode reads inputs as Gray code.
// - Function one counts by direction input.
// - Function two ignores direction, counts up.
// - Count is 24 bits, max 16777215.
// - Fault sets readable per-channel status bit.
// - Any counter fault drives fault indicator.
// - Error code identifies each fault.
`timescale 1ns/1ps
module dual_updown_gray_counter
  import counter_pkg::*;
(
  input  wire logic                  sys_clk_in,
  input  wire logic                  reset_n_in,
  input  wire logic                  clk_en_in,
  input  wire logic [ADDR_WIDTH-1:0] addr_in,
  input  wire logic [DATA_WIDTH-1:0] wdata_in,
  input  wire logic                  wr_in,
  input  wire logic                  rd_in,
  output logic      [DATA_WIDTH-1:0] rdata_out,
  input  wire field_in_s             field0_in,
  input  wire field_in_s             field1_in,
  output logic      [CHANNELS-1:0]   input_level_select_out,
  output logic                       fault_out,
  output logic                       irq_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    field_in_s [CHANNELS-1:0]                  sync1;
    field_in_s [CHANNELS-1:0]                  sync2;
    field_in_s [CHANNELS-1:0]                  prev;
    chan_cfg_s [CHANNELS-1:0]                  cfg;
    logic      [CHANNELS-1:0][COUNT_WIDTH-1:0] count;
    logic      [CHANNELS-1:0][7:0]             err;
    logic      [STAT_WIDTH-1:0]                status;
    logic      [STAT_WIDTH-1:0]                mask;
    logic      [DATA_WIDTH-1:0]                rdata;
  } state_s;

  state_s state_q;
  state_s state_d;

  localparam logic [COUNT_WIDTH-1:0] COUNT_MAX = {COUNT_WIDTH{1'b1}};

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // Read mux and fault bits are laid out for two 24-bit channels on a 32-bit port
  if (CHANNELS != 2 || COUNT_WIDTH != 24 || DATA_WIDTH != 32 || STAT_WIDTH != 2 * CHANNELS)
  begin : geometry_check
    $error("Unsupported counter geometry");
  end

  function automatic logic [GRAY_WIDTH-1:0] gray_to_bin(input logic [GRAY_WIDTH-1:0] g);
    logic [GRAY_WIDTH-1:0] b;
    b[GRAY_WIDTH-1] = g[GRAY_WIDTH-1];
    for (int i = GRAY_WIDTH-2; i >= 0; i--)
    begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : gray_to_bin

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    field_in_s             raw [CHANNELS];
    field_in_s             cur;
    logic                  rise_a;
    logic                  rise_z;
    logic                  up;
    logic [GRAY_WIDTH-1:0] gword;
    logic [STAT_WIDTH-1:0] set_bits;
    logic [STAT_WIDTH-1:0] clr_bits;
    raw[0]   = field0_in;
    raw[1]   = field1_in;
    cur      = '0;
    rise_a   = 1'b0;
    rise_z   = 1'b0;
    up       = 1'b0;
    gword    = '0;
    set_bits = '0;
    clr_bits = '0;
    state_d  = state_q;

    for (int ch = 0; ch < CHANNELS; ch++)
    begin
      // Two-stage synchroniser; only sync2 feeds logic
      state_d.sync1[ch] = raw[ch];
      state_d.sync2[ch] = state_q.sync1[ch];
      cur               = state_q.sync2[ch];
      state_d.prev[ch]  = cur;
      rise_a = cur.a & ~state_q.prev[ch].a;
      rise_z = cur.z & ~state_q.prev[ch].z;
      if (state_q.cfg[ch].enable)
      begin
        case (state_q.cfg[ch].mode)
          MODE_COUNT_DIR, MODE_COUNT_FIXED:
          begin
            // Function one follows B, function two always counts up
            up = (state_q.cfg[ch].mode == MODE_COUNT_FIXED) ? 1'b1 : cur.b;
            if (cur.z)
            begin
              state_d.count[ch] = '0;
            end
            else if (rise_a)
            begin
              // Wrap is flagged as a fault rather than silently lost
              if (up && state_q.count[ch] == COUNT_MAX)
              begin
                state_d.count[ch] = '0;
                set_bits[2*ch]    = 1'b1;
                state_d.err[ch]   = ERR_OVERFLOW;
              end
              else if (!up && state_q.count[ch] == '0)
              begin
                state_d.count[ch] = COUNT_MAX;
                set_bits[2*ch]    = 1'b1;
                state_d.err[ch]   = ERR_OVERFLOW;
              end
              else
              begin
                state_d.count[ch] = up ? state_q.count[ch] + 24'h000001
                                       : state_q.count[ch] - 24'h000001;
              end
            end
            if (rise_z)
            begin
              set_bits[2*ch+1] = 1'b1;
            end
          end
          MODE_DECODER:
          begin
            // Field drives absolute position on A,B,Z with A as MSB
            gword = {cur.a, cur.b, cur.z};
            state_d.count[ch] = {{(COUNT_WIDTH-GRAY_WIDTH){1'b0}}, gray_to_bin(gword)};
          end
          default:
          begin
            set_bits[2*ch]  = 1'b1;
            state_d.err[ch] = ERR_GRAY;
          end
        endcase
      end
    end

    // Register writes
    if (wr_in)
    begin
      case (addr_in)
        CFG0_ADDR:    state_d.cfg[0] = chan_cfg_s'(wdata_in[3:0]);
        CFG1_ADDR:    state_d.cfg[1] = chan_cfg_s'(wdata_in[3:0]);
        STATUS_ADDR:  clr_bits       = wdata_in[STAT_WIDTH-1:0];
        MASK_ADDR:    state_d.mask   = wdata_in[STAT_WIDTH-1:0];
        ERRCODE_ADDR:
        begin
          // A code raised in this cycle outlives a clear in the same cycle
          if (wdata_in[0] && !set_bits[0])
          begin
            state_d.err[0] = ERR_NONE;
          end
          if (wdata_in[1] && !set_bits[2])
          begin
            state_d.err[1] = ERR_NONE;
          end
        end
        default:
        begin
        end
      endcase
    end
    // Set wins over a simultaneous clear
    state_d.status = (state_q.status & ~clr_bits) | set_bits;

    // Register reads, data valid the cycle after the strobe
    state_d.rdata = '0;
    if (rd_in)
    begin
      case (addr_in)
        CFG0_ADDR:    state_d.rdata = {28'h0000000, state_q.cfg[0]};
        CFG1_ADDR:    state_d.rdata = {28'h0000000, state_q.cfg[1]};
        COUNT0_ADDR:  state_d.rdata = {8'h00, state_q.count[0]};
        COUNT1_ADDR:  state_d.rdata = {8'h00, state_q.count[1]};
        STATUS_ADDR:  state_d.rdata = {28'h0000000, state_q.status};
        MASK_ADDR:    state_d.rdata = {28'h0000000, state_q.mask};
        ERRCODE_ADDR: state_d.rdata = {16'h0000, state_q.err[1], state_q.err[0]};
        default:      state_d.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_q <= '0;
    end
    else if (clk_en_in)
    begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata_out = state_q.rdata;
  always_comb
  begin
    for (int ch = 0; ch < CHANNELS; ch++)
    begin
      input_level_select_out[ch] = state_q.cfg[ch].level_24v;
    end
  end
  assign fault_out = state_q.status[0] | state_q.status[2];
  assign irq_out   = |(state_q.status & state_q.mask);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  level_follows_cfg_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && wr_in && addr_in == CFG0_ADDR
      |=> input_level_select_out[0] == $past(wdata_in[CFG_LEVEL_BIT]))
    else $error("Level select differs from configuration");

  zero_clears_count_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && state_q.cfg[0].enable && state_q.cfg[0].mode == MODE_COUNT_DIR
      && state_q.sync2[0].z |=> state_q.count[0] == '0)
    else $error("Zero track did not clear count");

  fixed_counts_up_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && state_q.cfg[0].enable && state_q.cfg[0].mode == MODE_COUNT_FIXED
      && !state_q.sync2[0].z && state_q.sync2[0].a && !state_q.prev[0].a
      && state_q.count[0] != COUNT_MAX
      |=> state_q.count[0] == $past(state_q.count[0]) + 24'h000001)
    else $error("Function two did not count up");

  dir_counts_down_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && state_q.cfg[0].enable && state_q.cfg[0].mode == MODE_COUNT_DIR
      && !state_q.sync2[0].z && !state_q.sync2[0].b && state_q.sync2[0].a
      && !state_q.prev[0].a && state_q.count[0] != '0
      |=> state_q.count[0] == $past(state_q.count[0]) - 24'h000001)
    else $error("Function one did not count down");

  gray_decode_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && state_q.cfg[1].enable && state_q.cfg[1].mode == MODE_DECODER
      && state_q.sync2[1] == 3'b010 |=> state_q.count[1] == 24'h000003)
    else $error("Gray code decoded wrongly");

  sync_delay_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in ##1 clk_en_in |=> state_q.sync2[0] == $past(field0_in, 2))
    else $error("Input synchroniser delay wrong");

  fault_sticky_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    state_q.status[0] && !(wr_in && addr_in == STATUS_ADDR) |=> state_q.status[0])
    else $error("Fault bit lost without clear");

  fault_output_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && state_q.cfg[1].enable && state_q.cfg[1].mode == MODE_RESERVED
      |=> fault_out)
    else $error("Fault indicator not raised");

  overflow_code_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    $rose(state_q.status[0]) && state_q.cfg[0].mode != MODE_RESERVED
      |-> state_q.err[0] == ERR_OVERFLOW)
    else $error("Error code missing on fault");

  dir_counts_up_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && state_q.cfg[0].enable && state_q.cfg[0].mode == MODE_COUNT_DIR
      && !state_q.sync2[0].z && state_q.sync2[0].b && state_q.sync2[0].a
      && !state_q.prev[0].a && state_q.count[0] != COUNT_MAX
      |=> state_q.count[0] == $past(state_q.count[0]) + 24'h000001)
    else $error("Function one did not count up");

  reserved_code_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && state_q.cfg[1].enable && state_q.cfg[1].mode == MODE_RESERVED
      |=> state_q.err[1] == ERR_GRAY)
    else $error("Reserved mode gave no error code");

  irq_on_mask_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    clk_en_in && wr_in && addr_in == MASK_ADDR && wdata_in[0] && state_q.status[0]
      |=> irq_out)
    else $error("Unmasked fault raised no interrupt");

  enable_freeze_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    !clk_en_in |=> state_q.count[0] == $past(state_q.count[0]))
    else $error("Count moved while clock enable low");

endmodule : dual_updown_gray_counter

// ---- encoder_model.sv ----
// Field-side encoder model driving both counter channels
`timescale 1ns/1ps
module encoder_model
  import counter_pkg::*;
(
  input  wire logic sys_clk_in,
  output field_in_s field0_out,
  output field_in_s field1_out
);
  field_in_s f_q [2];

  assign field0_out = f_q[0];
  assign field1_out = f_q[1];

  initial
  begin
    f_q[0] = '0;
    f_q[1] = '0;
  end

  // ----------------------------------------------------------------
  // Field actions
  // ----------------------------------------------------------------
  // Two cycles high and low per pulse, wider than the minimum on purpose
  task pulse(input int ch, input logic dir, input int n);
    @(posedge sys_clk_in);
    f_q[ch].b <= dir;
    repeat (n)
    begin
      @(posedge sys_clk_in);
      f_q[ch].a <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      f_q[ch].a <= 1'b0;
      @(posedge sys_clk_in);
    end
    repeat (4) @(posedge sys_clk_in);
  endtask : pulse

  task gray(input int ch, input logic [2:0] pos);
    @(posedge sys_clk_in);
    f_q[ch] <= field_in_s'(pos ^ (pos >> 1));
    repeat (6) @(posedge sys_clk_in);
  endtask : gray

  task zero(input int ch, input logic lvl);
    @(posedge sys_clk_in);
    f_q[ch].z <= lvl;
    repeat (5) @(posedge sys_clk_in);
  endtask : zero
endmodule : encoder_model

// ---- dual_updown_gray_counter_tb.sv ----
// Self-checking bench for the dual up/down Gray-code counter
`timescale 1ns/1ps
module dual_updown_gray_counter_tb
  import counter_pkg::*;
;
  logic                  sys_clk_in = 1'b0;
  logic                  reset_n_in = 1'b0;
  logic                  clk_en_in  = 1'b1;
  logic                  wr_in      = 1'b0;
  logic                  rd_in      = 1'b0;
  logic [ADDR_WIDTH-1:0] addr_in    = '0;
  logic [DATA_WIDTH-1:0] wdata_in   = '0;
  logic [DATA_WIDTH-1:0] rdata_out;
  logic [DATA_WIDTH-1:0] v;
  logic [CHANNELS-1:0]   input_level_select_out;
  logic                  fault_out;
  logic                  irq_out;
  field_in_s             field0_in;
  field_in_s             field1_in;
  int                    err_total  = 0;
  int                    tests_run  = 0;
  int                    cycles     = 0;

  always #5 sys_clk_in = ~sys_clk_in;

  dual_updown_gray_counter dual_updown_gray_counter_i (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .field0_in(field0_in), .field1_in(field1_in),
    .input_level_select_out(input_level_select_out), .fault_out(fault_out),
    .irq_out(irq_out));

  encoder_model encoder_model_i (
    .sys_clk_in(sys_clk_in), .field0_out(field0_in), .field1_out(field1_in));

  // ----------------------------------------------------------------
  // Bus and report tasks
  // ----------------------------------------------------------------
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value %0s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    wr_in    <= 1'b1;
    addr_in  <= a;
    wdata_in <= d;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
    #1;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample there
  task rd(input logic [3:0] a);
    @(posedge sys_clk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask : rd

  task rdc(input string n, input logic [3:0] a, input logic [31:0] e);
    rd(a);
    chk(n, e, v);
  endtask : rdc

  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge sys_clk_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    wr(CFG0_ADDR, 32'h9);
    chk("level", 32'h1, 32'(input_level_select_out));
    wr(CFG1_ADDR, 32'h1);
    chk("level", 32'h3, 32'(input_level_select_out));
    rdc("cfg0", CFG0_ADDR, 32'h9);
    rdc("unmapped", 4'hf, 32'h0);
    wr(CFG0_ADDR, 32'h8);
    chk("level", 32'h2, 32'(input_level_select_out));
    $display("test level done");
    encoder_model_i.pulse(0, 1'b0, 4);
    rdc("count0 dir", COUNT0_ADDR, 32'hfffffc);
    encoder_model_i.pulse(0, 1'b1, 4);
    rdc("count0 back", COUNT0_ADDR, 32'h0);
    wr(STATUS_ADDR, 32'hf);
    wr(ERRCODE_ADDR, 32'h3);
    $display("test direction done");
    encoder_model_i.pulse(0, 1'b0, 1);
    rdc("count0 wrap", COUNT0_ADDR, 32'hffffff);
    rdc("status", STATUS_ADDR, 32'h1);
    rdc("errcode", ERRCODE_ADDR, 32'h1);
    chk("fault", 32'h1, 32'(fault_out));
    wr(MASK_ADDR, 32'h1);
    chk("irq", 32'h1, 32'(irq_out));
    wr(MASK_ADDR, 32'h0);
    chk("irq", 32'h0, 32'(irq_out));
    wr(STATUS_ADDR, 32'h1);
    chk("fault", 32'h0, 32'(fault_out));
    wr(ERRCODE_ADDR, 32'h1);
    rdc("errcode", ERRCODE_ADDR, 32'h0);
    $display("test fault done");
    encoder_model_i.zero(0, 1'b1);
    rdc("count0 zero", COUNT0_ADDR, 32'h0);
    rdc("status", STATUS_ADDR, 32'h2);
    encoder_model_i.zero(0, 1'b0);
    wr(STATUS_ADDR, 32'h2);
    wr(CFG0_ADDR, 32'ha);
    encoder_model_i.pulse(0, 1'b0, 3);
    encoder_model_i.pulse(0, 1'b1, 3);
    rdc("count0 fixed", COUNT0_ADDR, 32'h6);
    $display("test zero and fixed done");
    wr(CFG1_ADDR, 32'hc);
    for (int i = 0; i < 8; i++)
    begin
      encoder_model_i.gray(1, 3'(i));
      rdc("count1 gray", COUNT1_ADDR, 32'(i));
    end
    rdc("count0 kept", COUNT0_ADDR, 32'h6);
    // Pulses while the clock enable is low must leave the count alone
    @(posedge sys_clk_in);
    clk_en_in <= 1'b0;
    encoder_model_i.pulse(0, 1'b0, 2);
    clk_en_in <= 1'b1;
    rdc("count0 frozen", COUNT0_ADDR, 32'h6);
    $display("test decoder done");
    wr(CFG1_ADDR, 32'he);
    repeat (3) @(posedge sys_clk_in);
    rdc("errcode", ERRCODE_ADDR, 32'h200);
    rdc("status", STATUS_ADDR, 32'h4);
    chk("fault", 32'h1, 32'(fault_out));
    $display("test reserved done");
    @(posedge sys_clk_in);
    reset_n_in <= 1'b0;
    @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    #1;
    chk("fault after reset", 32'h0, 32'(fault_out));
    rdc("count1 reset", COUNT1_ADDR, 32'h0);
    $display("test reset done");
    tally_and_finish();
  end
endmodule : dual_updown_gray_counter_tb
